// >>> ppac_defines.vh
// Purpose: Named constants for the pump and self-calibration config bank
// Assumes: Included by bare name from every design file of the bank
// Notes: Definitions only, guarded against double inclusion
`ifndef PPAC_DEFINES_VH
`define PPAC_DEFINES_VH

// ************************************************************
// Serial frame layout
// ************************************************************
`define PPAC_ADDR_W 6
`define PPAC_DATA_W 24
`define PPAC_HDR_BITS 6'h07
`define PPAC_FRAME_BITS 6'h1f
`define PPAC_BITCNT_W 6

// ************************************************************
// Register offsets and reset values
// ************************************************************
`define PPAC_ADDR_PUMP 6'h09
`define PPAC_ADDR_CAL 6'h0a
`define PPAC_ADDR_DET 6'h0b
`define PPAC_RST_PUMP 24'h547264
`define PPAC_RST_CAL 24'h002046
`define PPAC_RST_DET 24'h078061

// ************************************************************
// Pump current register fields
// ************************************************************
`define PPAC_SINK_MSB 6
`define PPAC_SINK_LSB 0
`define PPAC_SOURCE_MSB 13
`define PPAC_SOURCE_LSB 7
`define PPAC_OFFSET_MSB 20
`define PPAC_OFFSET_LSB 14
`define PPAC_OFFSET_RAISE_BIT 21
`define PPAC_OFFSET_LOWER_BIT 22
`define PPAC_HIGH_CURRENT_BIT 23

// ************************************************************
// Tuning calibration register fields
// ************************************************************
`define PPAC_MEAS_MSB 2
`define PPAC_MEAS_LSB 0
`define PPAC_CAL_OFF_BIT 11
`define PPAC_CLKSEL_MSB 14
`define PPAC_CLKSEL_LSB 13
`define PPAC_RELOCK_BIT 17

// ************************************************************
// Detector and pump control register fields
// ************************************************************
`define PPAC_POLARITY_BIT 4
`define PPAC_RAISE_GATE_BIT 5
`define PPAC_LOWER_GATE_BIT 6
`define PPAC_RAISE_OVR_BIT 9
`define PPAC_LOWER_OVR_BIT 10
`define PPAC_MID_OVR_BIT 11

// ************************************************************
// Calibration engine timing
// ************************************************************
`define PPAC_MEAS_CNT_W 9
`define PPAC_DIV_CNT_W 5
`define PPAC_DIV_BY1 5'h00
`define PPAC_DIV_BY4 5'h03
`define PPAC_DIV_BY16 5'h0f
`define PPAC_DIV_BY32 5'h1f

`endif

// >>> ppac_serial_port.v
// Purpose: Serial control port slave for the config bank
// Assumes: Pins come from another domain and are synchronised here
// Notes: Frame is read flag, 6 address bits, 24 data bits, MSB first
`timescale 1ns/10ps
`include "ppac_defines.vh"

module ppac_serial_port (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire i_spi_sck,
  input wire i_spi_sen_n,
  input wire i_spi_sdi,
  input wire [`PPAC_DATA_W-1:0] i_rd_data,
  output reg o_spi_sdo,
  output reg o_wr_stb,
  output reg [`PPAC_ADDR_W-1:0] o_addr,
  output reg [`PPAC_DATA_W-1:0] o_wr_data
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  reg [2:0] sck_meta_q; // Stage 0 feeds stage 1 only
  reg [1:0] sen_meta_q; // Two-stage enable sync
  reg [1:0] sdi_meta_q; // Two-stage data sync
  reg [`PPAC_BITCNT_W-1:0] bitcnt_q; // Bits taken in this frame
  reg rd_q; // Frame is a read
  reg [`PPAC_DATA_W-1:0] shout_q; // Read data going out
  wire sck_rise;
  wire sck_fall;
  wire sen_act;

  // Edges from stages 1 and 2 only, never the first flop
  assign sck_rise = sck_meta_q[1] & ~sck_meta_q[2];
  assign sck_fall = ~sck_meta_q[1] & sck_meta_q[2];
  assign sen_act = ~sen_meta_q[1];

  // Synchroniser flops
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sck_meta_q <= 3'h0;
      sen_meta_q <= 2'h3;
      sdi_meta_q <= 2'h0;
    end else if (i_clk_en) begin
      sck_meta_q <= {sck_meta_q[1:0], i_spi_sck};
      sen_meta_q <= {sen_meta_q[0], i_spi_sen_n};
      sdi_meta_q <= {sdi_meta_q[0], i_spi_sdi};
    end
  end

  // ************************************************************
  // Frame shifter
  // ************************************************************
  // Partial frames never commit, so a torn write leaves registers intact
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bitcnt_q <= 6'h00;
      rd_q <= 1'b0;
      o_addr <= 6'h00;
      o_wr_data <= 24'h000000;
      o_wr_stb <= 1'b0;
      shout_q <= 24'h000000;
      o_spi_sdo <= 1'b0;
    end else if (i_clk_en) begin
      o_wr_stb <= 1'b0;
      if (!sen_act) begin
        // Idle: rearm and hold the data line low
        bitcnt_q <= 6'h00;
        o_spi_sdo <= 1'b0;
      end else if (sck_rise && bitcnt_q < `PPAC_FRAME_BITS) begin
        bitcnt_q <= bitcnt_q + 6'h01;
        if (bitcnt_q == 6'h00) begin
          rd_q <= sdi_meta_q[1];
        end else if (bitcnt_q < `PPAC_HDR_BITS) begin
          o_addr <= {o_addr[`PPAC_ADDR_W-2:0], sdi_meta_q[1]};
        end else begin
          o_wr_data <= {o_wr_data[`PPAC_DATA_W-2:0], sdi_meta_q[1]};
          // Last data bit of a write commits the word
          if (bitcnt_q == `PPAC_FRAME_BITS - 6'h01 && !rd_q) begin
            o_wr_stb <= 1'b1;
          end
        end
      end else if (sck_fall && rd_q && bitcnt_q >= `PPAC_HDR_BITS) begin
        // Read data leaves on falling edges, MSB first
        if (bitcnt_q == `PPAC_HDR_BITS) begin
          o_spi_sdo <= i_rd_data[`PPAC_DATA_W-1];
          shout_q <= {i_rd_data[`PPAC_DATA_W-2:0], 1'b0};
        end else begin
          o_spi_sdo <= shout_q[`PPAC_DATA_W-1];
          shout_q <= {shout_q[`PPAC_DATA_W-2:0], 1'b0};
        end
      end
    end
  end

endmodule // ppac_serial_port

// >>> ppac_config_bank.v
// Purpose: Pump current, self-calibration and detector control registers
// Assumes: Detector, divider and lock events come from logic on i_ref_clk
// Notes: Registers reached only through the serial control port
`timescale 1ns/10ps
`include "ppac_defines.vh"

module ppac_config_bank (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire i_spi_sck,
  input wire i_spi_sen_n,
  input wire i_spi_sdi,
  input wire i_pd_raise,
  input wire i_pd_lower,
  input wire i_cal_start,
  input wire i_ref_div_tick,
  input wire i_lock_lost,
  input wire i_lock_regained,
  output wire o_spi_sdo,
  output reg [6:0] o_pump_sink_current,
  output reg [6:0] o_pump_source_current,
  output reg [6:0] o_offset_magnitude,
  output reg o_offset_raise_on,
  output reg o_offset_lower_on,
  output reg o_high_current_pump_select,
  output reg o_pump_raise,
  output reg o_pump_lower,
  output reg o_pump_midpoint,
  output reg o_cal_clk_tick,
  output reg o_cal_busy,
  output reg o_cal_done,
  output reg o_relock_req
);

  // ************************************************************
  // State machine codes
  // ************************************************************
  localparam CAL_IDLE = 2'b00; // Waiting for a start
  localparam CAL_MEAS = 2'b01; // Counting divider cycles
  localparam CAL_DONE = 2'b10; // Reporting completion

  // ************************************************************
  // Declarations
  // ************************************************************
  reg [`PPAC_DATA_W-1:0] pump_current_config_q; // Pump currents word
  reg [`PPAC_DATA_W-1:0] tuning_calibration_config_q; // Calibration word
  reg [`PPAC_DATA_W-1:0] detector_pump_control_q; // Detector word
  reg [`PPAC_DATA_W-1:0] rd_data_d; // Read mux result
  reg [`PPAC_DIV_CNT_W-1:0] div_cnt_q; // Engine clock divider
  reg [`PPAC_MEAS_CNT_W-1:0] meas_cnt_q; // Cycles seen so far
  reg [1:0] cal_state_q; // Engine state
  reg [1:0] cal_state_d; // Engine next state
  reg div_pend_q; // Divider tick waiting for engine tick
  reg relock_tried_q; // One try spent since last lock
  reg det_raise_d; // Detector raise after polarity and gate
  reg det_lower_d; // Detector lower after polarity and gate
  reg pump_raise_d; // Pump raise after overrides
  reg pump_lower_d; // Pump lower after overrides
  reg pump_mid_d; // Midpoint after overrides
  wire wr_stb; // Committed write from the port
  wire [`PPAC_ADDR_W-1:0] wr_addr; // Address of the frame
  wire [`PPAC_DATA_W-1:0] wr_data; // Data of the frame
  wire engine_tick; // Engine clock enable
  wire [`PPAC_MEAS_CNT_W-1:0] meas_target; // Cycles to count
  wire [`PPAC_DIV_CNT_W-1:0] div_limit; // Divider wrap value
  wire cal_off; // Self calibration disabled
  wire relock_on; // Single relock allowed
  wire raise_ovr; // Force raise bit
  wire lower_ovr; // Force lower bit
  wire mid_ovr; // Force midpoint bit

  // ************************************************************
  // Decode functions
  // ************************************************************
  // Measurement length code to divider cycles
  function [`PPAC_MEAS_CNT_W-1:0] ppac_meas_len;
    input [2:0] code;
    begin
      case (code)
        3'h0: ppac_meas_len = 9'h001;
        3'h1: ppac_meas_len = 9'h002;
        3'h2: ppac_meas_len = 9'h004;
        3'h3: ppac_meas_len = 9'h008;
        3'h4: ppac_meas_len = 9'h020;
        3'h5: ppac_meas_len = 9'h040;
        3'h6: ppac_meas_len = 9'h080;
        default: ppac_meas_len = 9'h100;
      endcase
    end
  endfunction

  // Clock select code to divider wrap value
  function [`PPAC_DIV_CNT_W-1:0] ppac_div_limit;
    input [1:0] code;
    begin
      case (code)
        2'h0: ppac_div_limit = `PPAC_DIV_BY1;
        2'h1: ppac_div_limit = `PPAC_DIV_BY4;
        2'h2: ppac_div_limit = `PPAC_DIV_BY16;
        default: ppac_div_limit = `PPAC_DIV_BY32;
      endcase
    end
  endfunction

  // ************************************************************
  // Serial control port
  // ************************************************************
  ppac_serial_port u_port (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_spi_sck(i_spi_sck),
    .i_spi_sen_n(i_spi_sen_n),
    .i_spi_sdi(i_spi_sdi),
    .i_rd_data(rd_data_d),
    .o_spi_sdo(o_spi_sdo),
    .o_wr_stb(wr_stb),
    .o_addr(wr_addr),
    .o_wr_data(wr_data)
  );

  // ************************************************************
  // Register file
  // ************************************************************
  // Whole words are stored, reserved fields included
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pump_current_config_q <= `PPAC_RST_PUMP;
      tuning_calibration_config_q <= `PPAC_RST_CAL;
      detector_pump_control_q <= `PPAC_RST_DET;
    end else if (i_clk_en && wr_stb) begin
      case (wr_addr)
        `PPAC_ADDR_PUMP: pump_current_config_q <= wr_data;
        `PPAC_ADDR_CAL: tuning_calibration_config_q <= wr_data;
        `PPAC_ADDR_DET: detector_pump_control_q <= wr_data;
        default: ; // Other offsets belong elsewhere
      endcase
    end
  end

  // Read mux, unmapped offsets read as zero
  always @* begin
    case (wr_addr)
      `PPAC_ADDR_PUMP: rd_data_d = pump_current_config_q;
      `PPAC_ADDR_CAL: rd_data_d = tuning_calibration_config_q;
      `PPAC_ADDR_DET: rd_data_d = detector_pump_control_q;
      default: rd_data_d = 24'h000000;
    endcase
  end

  // ************************************************************
  // Field views
  // ************************************************************
  assign cal_off = tuning_calibration_config_q[`PPAC_CAL_OFF_BIT];
  assign relock_on = tuning_calibration_config_q[`PPAC_RELOCK_BIT];
  assign raise_ovr = detector_pump_control_q[`PPAC_RAISE_OVR_BIT];
  assign lower_ovr = detector_pump_control_q[`PPAC_LOWER_OVR_BIT];
  assign mid_ovr = detector_pump_control_q[`PPAC_MID_OVR_BIT];
  assign meas_target =
    ppac_meas_len(tuning_calibration_config_q[`PPAC_MEAS_MSB:`PPAC_MEAS_LSB]);
  assign div_limit =
    ppac_div_limit(tuning_calibration_config_q[`PPAC_CLKSEL_MSB:`PPAC_CLKSEL_LSB]);

  // Pump current outputs registered so the analog side sees clean levels
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // Whole word at its reset value, fields in bit order
      {o_high_current_pump_select, o_offset_lower_on, o_offset_raise_on,
        o_offset_magnitude, o_pump_source_current, o_pump_sink_current} <=
          `PPAC_RST_PUMP;
    end else if (i_clk_en) begin
      o_pump_sink_current <= pump_current_config_q[`PPAC_SINK_MSB:`PPAC_SINK_LSB];
      o_pump_source_current <=
        pump_current_config_q[`PPAC_SOURCE_MSB:`PPAC_SOURCE_LSB];
      o_offset_magnitude <=
        pump_current_config_q[`PPAC_OFFSET_MSB:`PPAC_OFFSET_LSB];
      o_offset_raise_on <= pump_current_config_q[`PPAC_OFFSET_RAISE_BIT];
      o_offset_lower_on <= pump_current_config_q[`PPAC_OFFSET_LOWER_BIT];
      // Only meaningful with an external oscillator and active filter
      o_high_current_pump_select <= pump_current_config_q[`PPAC_HIGH_CURRENT_BIT];
    end
  end

  // ************************************************************
  // Detector and pump steering
  // ************************************************************
  // Polarity swap, then gates, then test overrides
  always @* begin
    if (detector_pump_control_q[`PPAC_POLARITY_BIT]) begin
      det_raise_d = i_pd_lower;
      det_lower_d = i_pd_raise;
    end else begin
      det_raise_d = i_pd_raise;
      det_lower_d = i_pd_lower;
    end
    det_raise_d = det_raise_d & detector_pump_control_q[`PPAC_RAISE_GATE_BIT];
    det_lower_d = det_lower_d & detector_pump_control_q[`PPAC_LOWER_GATE_BIT];
    pump_raise_d = det_raise_d;
    pump_lower_d = det_lower_d;
    pump_mid_d = 1'b0;
    if (raise_ovr && !lower_ovr) begin
      // Forced raise, normal path shut off
      pump_raise_d = 1'b1;
      pump_lower_d = 1'b0;
    end else if (lower_ovr && !raise_ovr) begin
      // Forced lower, normal path shut off
      pump_raise_d = 1'b0;
      pump_lower_d = 1'b1;
    end else if (raise_ovr && lower_ovr) begin
      // Conflicting forces cancel, pump idles rather than fight
      pump_raise_d = 1'b0;
      pump_lower_d = 1'b0;
    end else if (mid_ovr) begin
      // Midpoint only when no force is active
      pump_raise_d = 1'b0;
      pump_lower_d = 1'b0;
      pump_mid_d = 1'b1;
    end
  end

  // Pump drive flops
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pump_raise <= 1'b0;
      o_pump_lower <= 1'b0;
      o_pump_midpoint <= 1'b0;
    end else if (i_clk_en) begin
      o_pump_raise <= pump_raise_d;
      o_pump_lower <= pump_lower_d;
      o_pump_midpoint <= pump_mid_d;
    end
  end

  // ************************************************************
  // Engine clock divider
  // ************************************************************
  // Software must keep the divided rate within the engine limit
  assign engine_tick = (div_cnt_q >= div_limit);

  // Free-running divider, wraps at the selected limit
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt_q <= 5'h00;
      o_cal_clk_tick <= 1'b0;
    end else if (i_clk_en) begin
      if (engine_tick) begin
        div_cnt_q <= 5'h00;
      end else begin
        div_cnt_q <= div_cnt_q + 5'h01;
      end
      o_cal_clk_tick <= engine_tick;
    end
  end

  // ************************************************************
  // Calibration measurement engine
  // ************************************************************
  // Next state; a too-short length is software's concern
  always @* begin
    cal_state_d = cal_state_q;
    case (cal_state_q)
      CAL_IDLE: begin
        if (i_cal_start && !cal_off) begin
          cal_state_d = CAL_MEAS;
        end
      end
      CAL_MEAS: begin
        if (cal_off) begin
          cal_state_d = CAL_IDLE;
        end else if (engine_tick && div_pend_q && meas_cnt_q + 9'h001 >= meas_target) begin
          cal_state_d = CAL_DONE;
        end
      end
      CAL_DONE: begin
        cal_state_d = CAL_IDLE;
      end
      default: begin
        cal_state_d = CAL_IDLE;
      end
    endcase
  end

  // Engine registers; divider ticks wait for the slower engine tick
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cal_state_q <= CAL_IDLE;
      meas_cnt_q <= 9'h000;
      div_pend_q <= 1'b0;
      o_cal_busy <= 1'b0;
      o_cal_done <= 1'b0;
    end else if (i_clk_en) begin
      cal_state_q <= cal_state_d;
      if (cal_state_q != CAL_MEAS) begin
        meas_cnt_q <= 9'h000;
        div_pend_q <= 1'b0;
      end else begin
        if (engine_tick && div_pend_q) begin
          meas_cnt_q <= meas_cnt_q + 9'h001;
        end
        // New tick wins over consumption in the same cycle
        if (i_ref_div_tick) begin
          div_pend_q <= 1'b1;
        end else if (engine_tick) begin
          div_pend_q <= 1'b0;
        end
      end
      o_cal_busy <= (cal_state_d == CAL_MEAS);
      o_cal_done <= (cal_state_d == CAL_DONE);
    end
  end

  // ************************************************************
  // Single relock attempt
  // ************************************************************
  // A loss in the rearm cycle still counts, the set wins
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      relock_tried_q <= 1'b0;
      o_relock_req <= 1'b0;
    end else if (i_clk_en) begin
      o_relock_req <= 1'b0;
      if (i_lock_lost && relock_on && !relock_tried_q) begin
        o_relock_req <= 1'b1;
        relock_tried_q <= 1'b1;
      end else if (i_lock_regained && !i_lock_lost) begin
        relock_tried_q <= 1'b0;
      end
    end
  end

endmodule // ppac_config_bank

// >>> ppac_config_bank_sva.sv
// Purpose: Port-level checks for the pump and self-cal config bank
// Assumes: One clock, async active-high reset, sees top ports only
// Notes: Register contents are judged by the bench through reads
`timescale 1ns/10ps

module ppac_config_bank_sva (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_spi_sen_n,
  input wire i_cal_start,
  input wire i_lock_lost,
  input wire i_lock_regained,
  input wire o_spi_sdo,
  input wire [6:0] o_pump_sink_current,
  input wire [6:0] o_pump_source_current,
  input wire [6:0] o_offset_magnitude,
  input wire o_offset_raise_on,
  input wire o_offset_lower_on,
  input wire o_high_current_pump_select,
  input wire o_pump_raise,
  input wire o_pump_lower,
  input wire o_pump_midpoint,
  input wire o_cal_busy,
  input wire o_cal_done,
  input wire o_relock_req
);
  // ************************************************************
  // Helper logic
  // ************************************************************
  reg tried_q; // Relock already issued, not yet rearmed
  reg [3:0] since_low_q; // Cycles since frame enable was low, saturating
  wire [23:0] pump_w = {o_high_current_pump_select, o_offset_lower_on, o_offset_raise_on,
    o_offset_magnitude, o_pump_source_current, o_pump_sink_current};

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  // Rearm wins so a same-cycle lost/regained never trips the once check
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tried_q <= 1'b0;
      since_low_q <= 4'hf;
    end else begin
      tried_q <= i_lock_regained ? 1'b0 : (o_relock_req ? 1'b1 : tried_q);
      since_low_q <= !i_spi_sen_n ? 4'h0 : (since_low_q == 4'hf ? 4'hf : since_low_q + 4'h1);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_RESET_FIELDS: assert property ($past(i_sys_rst) |-> pump_w == 24'h547264)
    else $error("pump fields not at reset value");
  AST_FIELDS_BY_FRAME: assert property (!$stable(pump_w) |-> since_low_q < 4'h8)
    else $error("pump fields changed outside a frame");
  AST_SDO_IDLE: assert property (i_spi_sen_n [*4] |-> !o_spi_sdo)
    else $error("read data driven outside a frame");
  AST_DONE_ENDS_BUSY: assert property (o_cal_done |-> !o_cal_busy && $past(o_cal_busy))
    else $error("done without ending a measurement");
  AST_DONE_PULSE: assert property (o_cal_done |=> !o_cal_done)
    else $error("done longer than one cycle");
  AST_BUSY_CAUSE: assert property ($rose(o_cal_busy) |-> $past(i_cal_start))
    else $error("measurement began without start");
  AST_RELOCK_CAUSE: assert property (o_relock_req |-> $past(i_lock_lost))
    else $error("relock without lock failure");
  AST_RELOCK_ONCE: assert property (o_relock_req |-> !tried_q)
    else $error("second relock before rearm");
  AST_MID_EXCLUSIVE: assert property (o_pump_midpoint |-> !o_pump_raise && !o_pump_lower)
    else $error("midpoint with a driven pump output");
endmodule // ppac_config_bank_sva

// >>> ppac_config_bank_tb.sv
// Purpose: Self-checking bench for the pump and self-cal config bank
// Assumes: Serial half periods of 4-5 clocks clear the 2-flop sync
// Notes: Detector table sweeps every override and gate combination
`timescale 1ns/10ps

module ppac_config_bank_tb;
  // ************************************************************
  // Stimulus and observation
  // ************************************************************
  reg i_ref_clk, i_sys_rst, i_spi_sck, i_spi_sen_n, i_spi_sdi, i_pd_raise, i_pd_lower;
  reg i_cal_start, i_ref_div_tick, i_lock_lost, i_lock_regained;
  wire o_spi_sdo, o_raise_on, o_lower_on, o_hc, o_raise, o_lower, o_mid, o_tick, o_busy, o_done;
  wire o_relock;
  wire [6:0] o_sink, o_src, o_ofs;
  wire [23:0] pump_o = {o_hc, o_lower_on, o_raise_on, o_ofs, o_src, o_sink};
  integer failures, n_tests;

  ppac_config_bank uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .i_spi_sck(i_spi_sck), .i_spi_sen_n(i_spi_sen_n), .i_spi_sdi(i_spi_sdi),
    .i_pd_raise(i_pd_raise), .i_pd_lower(i_pd_lower), .i_cal_start(i_cal_start),
    .i_ref_div_tick(i_ref_div_tick), .i_lock_lost(i_lock_lost),
    .i_lock_regained(i_lock_regained), .o_spi_sdo(o_spi_sdo), .o_pump_sink_current(o_sink),
    .o_pump_source_current(o_src), .o_offset_magnitude(o_ofs), .o_offset_raise_on(o_raise_on),
    .o_offset_lower_on(o_lower_on), .o_high_current_pump_select(o_hc), .o_pump_raise(o_raise),
    .o_pump_lower(o_lower), .o_pump_midpoint(o_mid), .o_cal_clk_tick(o_tick),
    .o_cal_busy(o_busy), .o_cal_done(o_done), .o_relock_req(o_relock));

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Inputs always move 2 ns after the rising edge
  task tick(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge i_ref_clk);
        #2;
      end
    end
  endtask

  task chk(input [23:0] got, input [23:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One frame: read flag, address, data, MSB first; sdo sampled late in low half
  task frame(input rd, input [5:0] a, input [23:0] d, output [23:0] q);
    reg [30:0] f;
    integer b;
    begin
      f = {rd, a, d};
      q = 24'h0;
      i_spi_sen_n = 1'b0;
      tick(4);
      for (b = 30; b >= 0; b = b - 1) begin
        i_spi_sdi = f[b];
        i_spi_sck = 1'b0;
        tick(5);
        if (b < 24) q = {q[22:0], o_spi_sdo};
        i_spi_sck = 1'b1;
        tick(4);
      end
      i_spi_sen_n = 1'b1;
      i_spi_sck = 1'b0;
      i_spi_sdi = 1'b0;
      tick(4);
    end
  endtask

  task wr(input [5:0] a, input [23:0] d);
    reg [23:0] q;
    begin
      frame(1'b0, a, d, q);
    end
  endtask

  task rdchk(input [5:0] a, input [23:0] e);
    reg [23:0] q;
    begin
      frame(1'b1, a, 24'h0, q);
      chk(q, e);
    end
  endtask

  // Counts relock requests in the three cycles after a failure pulse
  task lost(output [1:0] c);
    integer k;
    begin
      c = 2'd0;
      i_lock_lost = 1'b1;
      for (k = 0; k < 3; k = k + 1) begin
        tick(1);
        i_lock_lost = 1'b0;
        c = c + {1'b0, o_relock};
      end
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_regs;
    begin
      rdchk(6'h09, 24'h547264);
      rdchk(6'h0a, 24'h002046);
      rdchk(6'h0b, 24'h078061);
      chk(pump_o, 24'h547264);
      wr(6'h09, 24'h9a5b3c);
      chk(pump_o, 24'h9a5b3c);
      wr(6'h09, 24'h65a4c3);
      chk(pump_o, 24'h65a4c3);
      wr(6'h0a, 24'hfdf7bf);
      rdchk(6'h0a, 24'hfdf7bf);
      wr(6'h0d, 24'hffffff);
      rdchk(6'h0d, 24'h000000);
      rdchk(6'h09, 24'h65a4c3);
    end
  endtask

  // Polarity swap, gates, then overrides; both overrides leave all idle
  task t_det;
    reg [6:0] i;
    reg [2:0] j, e, m;
    reg r, l;
    begin
      for (i = 0; i < 64; i = i + 1) begin
        wr(6'h0b, {12'h078, i[5:3], 2'b00, i[2:0], 4'h1});
        for (j = 0; j < 4; j = j + 1) begin
          i_pd_raise = j[0];
          i_pd_lower = j[1];
          tick(1);
          r = (i[0] ? j[1] : j[0]) & i[1];
          l = (i[0] ? j[0] : j[1]) & i[2];
          e = {1'b0, l, r};
          m = 3'b111;
          if (i[3] && i[4]) e = 3'b000;
          else if (i[3]) begin e = 3'b001; m = 3'b101; end
          else if (i[4]) begin e = 3'b010; m = 3'b110; end
          else if (i[5]) e = 3'b100;
          chk({21'h0, {o_mid, o_lower, o_raise} & m}, {21'h0, e & m});
        end
      end
      wr(6'h0b, 24'h078061);
    end
  endtask

  task t_cal;
    integer c, n, s;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        wr(6'h0a, {9'h0, c[1:0], 13'h0040});
        n = 0;
        while (!o_tick && n < 100) begin tick(1); n = n + 1; end
        tick(1);
        n = 1;
        while (!o_tick && n < 100) begin tick(1); n = n + 1; end
        chk(n, c == 0 ? 1 : c == 1 ? 4 : c == 2 ? 16 : 32);
      end
      for (c = 0; c < 8; c = c + 1) begin
        wr(6'h0a, {21'h000008, c[2:0]});
        i_cal_start = 1'b1;
        tick(1);
        i_cal_start = 1'b0;
        n = 0;
        s = 0;
        while (!o_done && n < 1200) begin
          i_ref_div_tick = (n % 4 == 0);
          tick(1);
          s = s + i_ref_div_tick;
          n = n + 1;
        end
        i_ref_div_tick = 1'b0;
        n = c < 4 ? (1 << c) : (1 << (c + 1));
        chk(s >= n && s <= n + 1, 1);
      end
      wr(6'h0a, 24'h000840);
      i_cal_start = 1'b1;
      tick(1);
      i_cal_start = 1'b0;
      tick(3);
      chk(o_busy, 0);
    end
  endtask

  task t_relock;
    reg [1:0] c;
    begin
      wr(6'h0a, 24'h002046);
      lost(c);
      chk(c, 0);
      wr(6'h0a, 24'h022046);
      lost(c);
      chk(c, 1);
      lost(c);
      chk(c, 0);
      i_lock_regained = 1'b1;
      tick(1);
      i_lock_regained = 1'b0;
      lost(c);
      chk(c, 1);
    end
  endtask

  // ************************************************************
  // Run control
  // ************************************************************
  task summarize;
    begin
      if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    {i_spi_sck, i_spi_sdi, i_pd_raise, i_pd_lower, i_cal_start} = 5'h00;
    {i_ref_div_tick, i_lock_lost, i_lock_regained} = 3'h0;
    i_spi_sen_n = 1'b1;
    i_sys_rst = 1'b1;
    failures = 0;
    n_tests = 0;
    tick(3);
    i_sys_rst = 1'b0;
    tick(2);
    t_regs;
    t_det;
    t_cal;
    t_relock;
    summarize;
  end

  // Whole run is near 28k cycles; cut off at 90k cycles
  initial begin
    #(50 * 90000);
    failures = failures + 1;
    summarize;
  end
endmodule // ppac_config_bank_tb

bind ppac_config_bank ppac_config_bank_sva u_sva (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_spi_sen_n(i_spi_sen_n), .i_cal_start(i_cal_start),
  .i_lock_lost(i_lock_lost), .i_lock_regained(i_lock_regained), .o_spi_sdo(o_spi_sdo),
  .o_pump_sink_current(o_pump_sink_current), .o_pump_source_current(o_pump_source_current),
  .o_offset_magnitude(o_offset_magnitude), .o_offset_raise_on(o_offset_raise_on),
  .o_offset_lower_on(o_offset_lower_on), .o_pump_raise(o_pump_raise),
  .o_high_current_pump_select(o_high_current_pump_select), .o_pump_lower(o_pump_lower),
  .o_pump_midpoint(o_pump_midpoint), .o_cal_busy(o_cal_busy), .o_cal_done(o_cal_done),
  .o_relock_req(o_relock_req));
